// [verilog/rtcmh_top.sv]
// Minute counter, hour counter and alarm-minute comparator of a PC-style clock.
// Assumes a one-second tick from the time base on the same clock, and the
// rest of the alarm (seconds, hour) reported as one match level from outside.
//
// Notes on behaviour
// - Minute counter is eight bits, loadable and readable, binary or BCD.
// - Each second tick advances minute, hour and afternoon indicator as needed.
// - Minutes valid 0 to 59; larger values count up to FFh in binary (F9h in BCD), wrap to zero.
// - Alarm minute is readable; C0h to FFh matches every minute.
// - Wildcard minute alarms each minute only when alarm hour is wildcard too.
// - Alarm comparison happens once every second.
// - While the hold bit is set, time registers stop updating.
// - A format bit selects binary or BCD counting for all fields.
// - With alarm interrupt enabled, an alarm match raises the interrupt request.
// - An alarm match sets the alarm event flag in the status register.
// - Hour bit 7 is the afternoon indicator in 12-hour mode: 1 means PM.
// - Hour field is bits 6 to 0, loaded and read in binary or BCD.
// - Out-of-range hour: whole byte counts up until valid (in 24-hour mode up to FFh in binary, F9h in BCD, then wraps to zero), then stays valid.
// - A seven-bit index written at the index port selects the data port target.
// - One hour-mode bit in the second control register picks 12 or 24 hours.
`timescale 1ns/1ps
`include "rtcmh_consts.svh"

module rtcmh_top
    import rtcmh_pkg::*;
#(
    parameter int IDX_W = 7                              // Index port width.
) (
    input  wire logic        i_mclk,                     // 20 MHz clock.
    input  wire logic        i_srst,                     // Synchronous reset, high.
    input  wire logic        i_sec_tick,                 // One-second enable pulse.
    input  wire logic        i_io_wr,                    // I/O write strobe.
    input  wire logic        i_io_rd,                    // I/O read strobe.
    input  wire logic [7:0]  i_io_addr,                  // I/O port address.
    input  wire logic [7:0]  i_io_wdata,                 // I/O write data.
    input  wire logic        i_alarm_rest_match,         // Seconds and hour alarm match.
    output logic      [7:0]  o_io_rdata,                 // Registered read data.
    output logic             o_irq                       // Alarm interrupt request.
);

    // Only a seven-bit index fits the documented port layout.
    if (IDX_W != 7) begin : g_bad_idx
        $error("rtcmh_top: IDX_W must be 7");
    end

    // Format-aware increment of one byte; BCD skips the low-nibble codes A to F.
    function automatic rtcmh_byte_t inc_val(input rtcmh_byte_t v, input logic bcd);
        rtcmh_byte_t r;
        r = v + 8'h01;
        if (bcd && v[3:0] == 4'h9) begin
            r = v + 8'h07;
        end
        return r;
    endfunction : inc_val

    // Encodes a decimal count in the selected format.
    function automatic rtcmh_byte_t enc(input int unsigned n, input logic bcd);
        rtcmh_byte_t r;
        r = bcd ? rtcmh_byte_t'(((n / 10) << 4) | (n % 10)) : rtcmh_byte_t'(n);
        return r;
    endfunction : enc

    rtcmh_byte_t      minute_counter_ff;
    rtcmh_byte_t      nxt_minute_counter;
    rtcmh_byte_t      alarm_minute_compare_ff;
    rtcmh_byte_t      nxt_alarm_minute_compare;
    rtcmh_byte_t      hour_counter_ff;
    rtcmh_byte_t      nxt_hour_counter;
    rtcmh_byte_t      clock_control_second_ff;
    rtcmh_byte_t      nxt_clock_control_second;
    logic [IDX_W-1:0] clock_index_port_ff;
    logic [IDX_W-1:0] nxt_clock_index_port;
    logic             alarm_event_flag_ff;
    logic             nxt_alarm_event_flag;
    rtcmh_byte_t      rdata_ff;
    rtcmh_byte_t      nxt_rdata;

    logic        hold;
    logic        alarm_irq_enable;
    logic        h24;
    rtcmh_fmt_e  number_format_select;
    logic        bcd;
    logic        wr_data;
    logic        rd_data;
    logic        run_tick;
    logic        min_wrap;
    logic        hour_valid;
    logic        min_match;
    logic        alarm_hit;
    logic [6:0]  hour_field;
    logic        afternoon_indicator;

    // Loose control bits live in the second control register.
    assign hold                 = clock_control_second_ff[`RTCMH_CTL_HOLD_BIT];
    assign alarm_irq_enable     = clock_control_second_ff[`RTCMH_CTL_AIE_BIT];
    assign h24                  = clock_control_second_ff[`RTCMH_CTL_H24_BIT];
    assign number_format_select = clock_control_second_ff[`RTCMH_CTL_BIN_BIT]
                                ? RTCMH_FMT_BIN : RTCMH_FMT_BCD;
    assign bcd                  = (number_format_select == RTCMH_FMT_BCD);

    // Port decode; the index port is write-only and the data port is indirect.
    assign wr_data  = i_io_wr && (i_io_addr == `RTCMH_PORT_DATA);
    assign rd_data  = i_io_rd && (i_io_addr == `RTCMH_PORT_DATA);
    assign run_tick = i_sec_tick && !hold;

    // Only 59 rolls into the hour; a wrap from FFh is catch-up, not a new hour.
    assign min_wrap = (minute_counter_ff == enc(`RTCMH_MIN_LAST, bcd));
    assign hour_field          = hour_counter_ff[6:0];
    assign afternoon_indicator = hour_counter_ff[`RTCMH_AFTERNOON_BIT];

    // Range check of the hour as loaded, in the current mode and format.
    always_comb begin
        if (h24) begin
            hour_valid = (hour_counter_ff <= enc(`RTCMH_H24_LAST, bcd));
        end else begin
            hour_valid = (hour_field != 7'h00)
                      && ({1'b0, hour_field} <= enc(`RTCMH_H12_LAST, bcd));
        end
        if (bcd && (hour_counter_ff[3:0] > 4'h9)) begin
            hour_valid = 1'b0;
        end
    end

    // Alarm minute match; a top code of 11 is a wildcard for any minute.
    assign min_match = (alarm_minute_compare_ff[7:6] == `RTCMH_WILD_TOP)
                    || (alarm_minute_compare_ff == minute_counter_ff);
    // The hour wildcard reaches this block through the rest-match level.
    assign alarm_hit = i_sec_tick && min_match && i_alarm_rest_match;

    // Next values of the time registers; a software load beats the tick.
    always_comb begin
        nxt_minute_counter = minute_counter_ff;
        nxt_hour_counter   = hour_counter_ff;
        if (run_tick) begin
            nxt_minute_counter = min_wrap ? 8'h00 : inc_val(minute_counter_ff, bcd);
            if (min_wrap) begin
                if (!hour_valid) begin
                    nxt_hour_counter = inc_val(hour_counter_ff, bcd);
                end else if (h24) begin
                    nxt_hour_counter = (hour_counter_ff == enc(`RTCMH_H24_LAST, bcd))
                                     ? 8'h00 : inc_val(hour_counter_ff, bcd);
                end else if ({1'b0, hour_field} == enc(`RTCMH_H12_LAST, bcd)) begin
                    nxt_hour_counter = {afternoon_indicator, 7'h01};
                end else if ({1'b0, hour_field} == enc(`RTCMH_H12_FLIP, bcd)) begin
                    nxt_hour_counter = {~afternoon_indicator,
                                        7'(enc(`RTCMH_H12_LAST, bcd))};
                end else begin
                    nxt_hour_counter = {afternoon_indicator,
                                        7'(inc_val({1'b0, hour_field}, bcd))};
                end
            end
        end
        if (wr_data && clock_index_port_ff == `RTCMH_IDX_MINUTE) begin
            nxt_minute_counter = i_io_wdata;
        end
        if (wr_data && clock_index_port_ff == `RTCMH_IDX_HOUR) begin
            nxt_hour_counter = i_io_wdata;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            minute_counter_ff <= `RTCMH_RST_MINUTE;
            hour_counter_ff   <= `RTCMH_RST_HOUR;
        end else begin
            minute_counter_ff <= nxt_minute_counter;
            hour_counter_ff   <= nxt_hour_counter;
        end
    end

    // Next values of the port and control registers and the event flag.
    always_comb begin
        nxt_clock_index_port     = clock_index_port_ff;
        nxt_alarm_minute_compare = alarm_minute_compare_ff;
        nxt_clock_control_second = clock_control_second_ff;
        nxt_alarm_event_flag     = alarm_event_flag_ff;
        if (i_io_wr && i_io_addr == `RTCMH_PORT_INDEX) begin
            nxt_clock_index_port = i_io_wdata[IDX_W-1:0];
        end
        if (wr_data && clock_index_port_ff == `RTCMH_IDX_ALARM_MINUTE_FIELD) begin
            nxt_alarm_minute_compare = i_io_wdata;
        end
        if (wr_data && clock_index_port_ff == `RTCMH_IDX_CONTROL) begin
            nxt_clock_control_second = i_io_wdata;
        end
        // Reading status clears the flag, but a same-cycle alarm must survive.
        if (rd_data && clock_index_port_ff == `RTCMH_IDX_STATUS) begin
            nxt_alarm_event_flag = 1'b0;
        end
        if (alarm_hit) begin
            nxt_alarm_event_flag = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            clock_index_port_ff     <= `RTCMH_RST_INDEX;
            alarm_minute_compare_ff <= `RTCMH_RST_ALARM_MINUTE_FIELD;
            clock_control_second_ff <= `RTCMH_RST_CONTROL;
            alarm_event_flag_ff     <= 1'b0;
        end else begin
            clock_index_port_ff     <= nxt_clock_index_port;
            alarm_minute_compare_ff <= nxt_alarm_minute_compare;
            clock_control_second_ff <= nxt_clock_control_second;
            alarm_event_flag_ff     <= nxt_alarm_event_flag;
        end
    end

    // Read mux; the data is captured on the strobe and held until the next read.
    always_comb begin
        nxt_rdata = rdata_ff;
        if (rd_data) begin
            case (clock_index_port_ff)
                `RTCMH_IDX_MINUTE:     nxt_rdata = minute_counter_ff;
                `RTCMH_IDX_ALARM_MINUTE_FIELD: nxt_rdata = alarm_minute_compare_ff;
                `RTCMH_IDX_HOUR:       nxt_rdata = hour_counter_ff;
                `RTCMH_IDX_CONTROL:    nxt_rdata = clock_control_second_ff;
                `RTCMH_IDX_STATUS: begin
                    nxt_rdata = 8'h00;
                    nxt_rdata[`RTCMH_STA_AEF_BIT] = alarm_event_flag_ff;
                end
                default:               nxt_rdata = 8'h00;
            endcase
        end else if (i_io_rd && i_io_addr == `RTCMH_PORT_INDEX) begin
            nxt_rdata = 8'h00;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_io_rdata = rdata_ff;
    // Level request; it stays up until software reads the status register or clears the interrupt enable bit.
    assign o_irq      = alarm_event_flag_ff && alarm_irq_enable;

    // Checks of the timekeeping behaviour.
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    sequence s_quiet_tick;
        run_tick && !wr_data;
    endsequence

    sequence s_min_rollover;
        s_quiet_tick ##0 min_wrap;
    endsequence

    a_hold_freeze: assert property (
        hold && !wr_data |=> $stable(minute_counter_ff) && $stable(hour_counter_ff))
        else $error("time changed while held");

    a_min_rollover: assert property (
        s_min_rollover |=> minute_counter_ff == 8'h00)
        else $error("minute did not roll over to zero");

    a_min_ff_wrap: assert property (
        s_quiet_tick ##0 minute_counter_ff == 8'hFF
        |=> minute_counter_ff == 8'h00 && $stable(hour_counter_ff))
        else $error("minute FFh wrap wrong or carried into hour");

    a_hour_carry: assert property (
        s_min_rollover ##0 hour_valid |=> !$stable(hour_counter_ff))
        else $error("hour did not advance on minute rollover");

    a_pm_flip: assert property (
        s_min_rollover ##0 hour_valid && !h24
        && {1'b0, hour_field} == enc(`RTCMH_H12_FLIP, bcd)
        |=> afternoon_indicator != $past(afternoon_indicator))
        else $error("afternoon indicator did not toggle at eleven");

    // A status read in the cycle after the set may legally clear the flag again.
    a_alarm_flag: assert property (
        alarm_hit |=> alarm_event_flag_ff
        ##1 (alarm_event_flag_ff
             || $past(rd_data && clock_index_port_ff == `RTCMH_IDX_STATUS)))
        else $error("alarm match did not set event flag");

    a_wild_any: assert property (
        i_sec_tick && i_alarm_rest_match
        && alarm_minute_compare_ff[7:6] == `RTCMH_WILD_TOP
        |=> alarm_event_flag_ff)
        else $error("wildcard alarm minute did not match");

    a_irq_follow: assert property (
        alarm_hit && alarm_irq_enable && !(wr_data && clock_index_port_ff == `RTCMH_IDX_CONTROL)
        |=> o_irq)
        else $error("enabled alarm did not raise interrupt");

    a_min_load: assert property (
        wr_data && clock_index_port_ff == `RTCMH_IDX_MINUTE
        |=> minute_counter_ff == $past(i_io_wdata) ##1 1'b1)
        else $error("minute load lost");

    a_no_tick_still: assert property (
        !i_sec_tick && !wr_data |=> $stable(minute_counter_ff) && $stable(hour_counter_ff))
        else $error("time moved without a second tick");

endmodule : rtcmh_top

// [verilog/rtcmh_consts.svh]
// Constants of the minute, hour and alarm-minute timekeeping block.
// Assumes inclusion by bare name from the block's module and the bench.
`ifndef RTCMH_CONSTS_SVH
`define RTCMH_CONSTS_SVH
`define RTCMH_PORT_INDEX     8'h70
`define RTCMH_PORT_DATA      8'h71
`define RTCMH_IDX_MINUTE     7'h02
`define RTCMH_IDX_ALARM_MINUTE_FIELD 7'h03
`define RTCMH_IDX_HOUR       7'h04
`define RTCMH_IDX_CONTROL    7'h0B
`define RTCMH_IDX_STATUS     7'h0C
`define RTCMH_CTL_HOLD_BIT   7
`define RTCMH_CTL_AIE_BIT    5
`define RTCMH_CTL_BIN_BIT    2
`define RTCMH_CTL_H24_BIT    1
`define RTCMH_STA_AEF_BIT    5
`define RTCMH_AFTERNOON_BIT  7
`define RTCMH_MIN_LAST       59
`define RTCMH_H24_LAST       23
`define RTCMH_H12_LAST       12
`define RTCMH_H12_FLIP       11
`define RTCMH_RST_MINUTE     8'h00
`define RTCMH_RST_ALARM_MINUTE_FIELD 8'h00
`define RTCMH_RST_HOUR       8'h12
`define RTCMH_RST_CONTROL    8'h00
`define RTCMH_RST_INDEX      7'h00
`define RTCMH_WILD_TOP       2'h3
`endif

// [verilog/rtcmh_pkg.sv]
// Types shared by the minute, hour and alarm-minute timekeeping block.
// Assumes the constants header sits on the include path.
package rtcmh_pkg;
    typedef logic [7:0] rtcmh_byte_t;
    typedef enum logic [1:0] {
        RTCMH_FMT_BCD = 2'b01,
        RTCMH_FMT_BIN = 2'b10
    } rtcmh_fmt_e;
endpackage : rtcmh_pkg

// [dv/rtc_minute_hour_alarm_tb.sv]
// Self-checking bench for the minute, hour and alarm-minute block.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`include "rtcmh_consts.svh"

module rtc_minute_hour_alarm_tb
    import rtcmh_pkg::*;
;
    logic        i_mclk;              // Bench clock.
    logic        i_srst;              // Synchronous reset.
    logic        i_sec_tick;          // Second tick.
    logic        i_io_wr;             // Write strobe.
    logic        i_io_rd;             // Read strobe.
    logic [7:0]  i_io_addr;           // Port address.
    logic [7:0]  i_io_wdata;          // Write data.
    logic        i_alarm_rest_match;  // Rest of the alarm matches.
    rtcmh_byte_t o_io_rdata;          // Read data.
    logic        o_irq;               // Interrupt request.
    int          n_errors;            // Mismatches seen.
    int          checks_done;         // Comparisons made.
    int          cycles;              // Cycles since start.
    localparam int LIMIT = 3000;      // Whole run needs well under this.

    rtcmh_top rtcmh_top_i (
        .i_mclk             (i_mclk),
        .i_srst             (i_srst),
        .i_sec_tick         (i_sec_tick),
        .i_io_wr            (i_io_wr),
        .i_io_rd            (i_io_rd),
        .i_io_addr          (i_io_addr),
        .i_io_wdata         (i_io_wdata),
        .i_alarm_rest_match (i_alarm_rest_match),
        .o_io_rdata         (o_io_rdata),
        .o_irq              (o_irq)
    );

    // Clock of 50 ns period.
    always #25 i_mclk = ~i_mclk;

    // A hung run counts as a failure and still reaches the verdict.
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_errors = n_errors + 1;
            summarize();
        end
    end

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (n_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // Compares one value and reports a mismatch.
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One strobe cycle, then an idle cycle so strobes never merge.
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        i_io_wr    <= w;
        i_io_rd    <= r;
        i_io_addr  <= a;
        i_io_wdata <= d;
        @(posedge i_mclk);
        i_io_wr <= 1'b0;
        i_io_rd <= 1'b0;
        @(posedge i_mclk);
    endtask : bus

    // Index write followed by a data write.
    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        bus(1'b1, 1'b0, `RTCMH_PORT_INDEX, {1'b0, idx});
        bus(1'b1, 1'b0, `RTCMH_PORT_DATA, d);
    endtask : wr

    // Index write followed by a data read, then a comparison.
    task automatic expect_reg(input string name, input logic [6:0] idx, input logic [7:0] exp);
        bus(1'b1, 1'b0, `RTCMH_PORT_INDEX, {1'b0, idx});
        bus(1'b0, 1'b1, `RTCMH_PORT_DATA, 8'h00);
        chk(name, exp, o_io_rdata);
    endtask : expect_reg

    // One-cycle second tick with the given rest-of-alarm level.
    task automatic tick(input logic rest);
        i_sec_tick         <= 1'b1;
        i_alarm_rest_match <= rest;
        @(posedge i_mclk);
        i_sec_tick <= 1'b0;
        @(posedge i_mclk);
    endtask : tick

    // Reset values, the index port read and an unmapped index.
    task automatic t_reset();
        chk("irq", 8'h00, {7'h00, o_irq});
        expect_reg("minute", `RTCMH_IDX_MINUTE, 8'h00);
        expect_reg("hour", `RTCMH_IDX_HOUR, 8'h12);
        bus(1'b0, 1'b1, `RTCMH_PORT_INDEX, 8'h00);
        chk("index_read", 8'h00, o_io_rdata);
        wr(7'h0E, 8'h5A);
        expect_reg("unmapped", 7'h0E, 8'h00);
    endtask : t_reset

    // Minute rollover carries into the hour, in BCD and in binary.
    task automatic t_rollover();
        wr(`RTCMH_IDX_CONTROL, 8'h02);
        wr(`RTCMH_IDX_HOUR, 8'h01);
        wr(`RTCMH_IDX_MINUTE, 8'h58);
        expect_reg("minute_load", `RTCMH_IDX_MINUTE, 8'h58);
        tick(1'b0);
        expect_reg("minute_bcd", `RTCMH_IDX_MINUTE, 8'h59);
        tick(1'b0);
        expect_reg("minute_carry", `RTCMH_IDX_MINUTE, 8'h00);
        expect_reg("hour_carry", `RTCMH_IDX_HOUR, 8'h02);
        wr(`RTCMH_IDX_CONTROL, 8'h06);
        wr(`RTCMH_IDX_HOUR, 8'h17);
        wr(`RTCMH_IDX_MINUTE, 8'h3B);
        tick(1'b0);
        expect_reg("minute_bin", `RTCMH_IDX_MINUTE, 8'h00);
        expect_reg("hour_bin_wrap", `RTCMH_IDX_HOUR, 8'h00);
    endtask : t_rollover

    // Out-of-range minute and hour count through FFh and wrap.
    task automatic t_wrap();
        wr(`RTCMH_IDX_HOUR, 8'h05);
        wr(`RTCMH_IDX_MINUTE, 8'hFE);
        tick(1'b0);
        expect_reg("minute_ff", `RTCMH_IDX_MINUTE, 8'hFF);
        tick(1'b0);
        expect_reg("minute_wrap", `RTCMH_IDX_MINUTE, 8'h00);
        expect_reg("hour_kept", `RTCMH_IDX_HOUR, 8'h05);
        wr(`RTCMH_IDX_HOUR, 8'hFE);
        wr(`RTCMH_IDX_MINUTE, 8'h3B);
        tick(1'b0);
        expect_reg("hour_ff", `RTCMH_IDX_HOUR, 8'hFF);
        wr(`RTCMH_IDX_MINUTE, 8'h3B);
        tick(1'b0);
        expect_reg("hour_wrap", `RTCMH_IDX_HOUR, 8'h00);
    endtask : t_wrap

    // Twelve-hour mode: 11 to 12 sets PM, 12 to 1 keeps it.
    task automatic t_twelve();
        wr(`RTCMH_IDX_CONTROL, 8'h00);
        wr(`RTCMH_IDX_HOUR, 8'h11);
        wr(`RTCMH_IDX_MINUTE, 8'h59);
        tick(1'b0);
        expect_reg("hour_pm", `RTCMH_IDX_HOUR, 8'h92);
        wr(`RTCMH_IDX_MINUTE, 8'h59);
        tick(1'b0);
        expect_reg("hour_one", `RTCMH_IDX_HOUR, 8'h81);
    endtask : t_twelve

    // Hold freezes counting while the alarm compare keeps running.
    task automatic t_alarm();
        wr(`RTCMH_IDX_CONTROL, 8'hA6);
        wr(`RTCMH_IDX_MINUTE, 8'h10);
        wr(`RTCMH_IDX_ALARM_MINUTE_FIELD, 8'h10);
        tick(1'b0);
        expect_reg("minute_hold", `RTCMH_IDX_MINUTE, 8'h10);
        chk("irq_rest_low", 8'h00, {7'h00, o_irq});
        tick(1'b1);
        chk("irq_match", 8'h01, {7'h00, o_irq});
        expect_reg("flag_set", `RTCMH_IDX_STATUS, 8'h20);
        chk("irq_cleared", 8'h00, {7'h00, o_irq});
        wr(`RTCMH_IDX_ALARM_MINUTE_FIELD, 8'h11);
        tick(1'b1);
        chk("irq_mismatch", 8'h00, {7'h00, o_irq});
        wr(`RTCMH_IDX_ALARM_MINUTE_FIELD, 8'hC0);
        expect_reg("alarm_read", `RTCMH_IDX_ALARM_MINUTE_FIELD, 8'hC0);
        tick(1'b1);
        chk("irq_wild", 8'h01, {7'h00, o_irq});
        expect_reg("flag_wild", `RTCMH_IDX_STATUS, 8'h20);
        wr(`RTCMH_IDX_CONTROL, 8'h86);
        expect_reg("control_read", `RTCMH_IDX_CONTROL, 8'h86);
        wr(`RTCMH_IDX_ALARM_MINUTE_FIELD, 8'hFF);
        tick(1'b1);
        chk("irq_masked", 8'h00, {7'h00, o_irq});
        expect_reg("flag_masked", `RTCMH_IDX_STATUS, 8'h20);
    endtask : t_alarm

    // A reset in mid-run returns read data and registers to their reset values.
    task automatic t_rerun();
        i_srst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_srst <= 1'b0;
        @(posedge i_mclk);
        chk("rdata_reset", 8'h00, o_io_rdata);
        chk("irq_reset", 8'h00, {7'h00, o_irq});
        expect_reg("control_reset", `RTCMH_IDX_CONTROL, 8'h00);
        expect_reg("alarm_reset", `RTCMH_IDX_ALARM_MINUTE_FIELD, 8'h00);
        expect_reg("minute_reset", `RTCMH_IDX_MINUTE, 8'h00);
    endtask : t_rerun

    // Main sequence.
    initial begin
        i_mclk             = 1'b0;
        i_srst             = 1'b1;
        i_sec_tick         = 1'b0;
        i_io_wr            = 1'b0;
        i_io_rd            = 1'b0;
        i_io_addr          = 8'h00;
        i_io_wdata         = 8'h00;
        i_alarm_rest_match = 1'b0;
        n_errors           = 0;
        checks_done        = 0;
        cycles             = 0;
        repeat (5) @(posedge i_mclk);
        i_srst <= 1'b0;
        @(posedge i_mclk);
        t_reset();
        t_rollover();
        t_wrap();
        t_twelve();
        t_alarm();
        t_rerun();
        summarize();
    end
endmodule : rtc_minute_hour_alarm_tb
